// *** design/cmp_ctrl.sv ***
// Summary of operation
// two channels filter, flag, interrupt and drive outputs independently
// shared detector serves either comparators or voltage monitors, never both
// channel 1 flag in monitor control reg, channel 2 in detect reg
// flag high means input at or above the reference
// rising or falling crossing of the reference is the event
// interrupt on rising, falling or both crossings as configured
// each channel interrupt is maskable or non-maskable
// filter sample period is two low-speed clocks multiplied by 1,2,4,8
// each result drives its own output pin, optionally inverted
// reference pin serves as reference for both channels
// invert bit zero passes result, one inverts it
// output-enable bit zero blocks pin, one drives result
// edge-select zero picks one edge, one picks both edges
// interrupt type bits only count while global select enable is set
// comparator outputs pass two flip-flops before use
// filter accepts a level only after consecutive samples agree
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp1_analog_in,
    input wire logic cmp2_analog_in,
    input wire logic low_speed_osc_clock,
    output logic cmp1_result_out,
    output logic cmp2_result_out,
    output logic detect_use_monitor,
    output logic irq,
    output logic nmi
);

    // ************************************************************
    // registers
    // ************************************************************
    cmp_ctrl_t ctrl;
    cmp_cfg_t cfg;
    logic [1:0] both_edges, irq_status, irq_enable, clr_mask;
    logic [1:0] level, evt, act, raw;
    logic tick;
    logic aw_full, w_full, rd_hit, wr_hit;
    logic [IDX_W-1:0] aw_idx, ar_idx;
    logic [DATA_W-1:0] w_data, rd_word;
    logic [3:0] w_strb;
    logic wr_fire, next_aw_full, next_w_full, next_rvalid;

    // the comparator front end takes one raw input per channel, channel 1 in bit 0
    assign raw = {cmp2_analog_in, cmp1_analog_in};
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign next_aw_full = (aw_full && !wr_fire)
        || (s_axi_awvalid && s_axi_awready);
    assign next_w_full = (w_full && !wr_fire)
        || (s_axi_wvalid && s_axi_wready);
    assign next_rvalid = (s_axi_rvalid && !s_axi_rready)
        || (s_axi_arvalid && s_axi_arready);

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_idx <= '0;
            w_data <= '0;
            w_strb <= 4'h0;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready <= !next_w_full;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_comb begin
        wr_hit = 1'b0;
        if (aw_idx == IDX_CTRL || aw_idx == IDX_EDGE) begin
            wr_hit = 1'b1;
        end else if (aw_idx == IDX_DETECT || aw_idx == IDX_MON1) begin
            wr_hit = 1'b1;
        end else if (aw_idx >= IDX_CFG && aw_idx <= IDX_ENABLE) begin
            wr_hit = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control registers; only byte lane 0 carries bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RST;
            cfg <= CFG_RST;
            both_edges <= EDGE_RST;
            irq_enable <= IRQ_RST;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_idx == IDX_CTRL) begin
                ctrl <= w_data[7:0] & 8'hBF;
            end else if (aw_idx == IDX_EDGE) begin
                both_edges <= {w_data[EDGE2_BIT], w_data[EDGE1_BIT]};
            end else if (aw_idx == IDX_CFG) begin
                cfg <= w_data[7:0];
            end else if (aw_idx == IDX_ENABLE) begin
                irq_enable <= w_data[1:0];
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (ar_idx == IDX_CTRL) begin
            rd_word[7:0] = ctrl;
        end else if (ar_idx == IDX_EDGE) begin
            rd_word[EDGE2_BIT:EDGE1_BIT] = both_edges;
        end else if (ar_idx == IDX_DETECT) begin
            rd_word[FLAG_BIT] = level[1];
        end else if (ar_idx == IDX_MON1) begin
            rd_word[FLAG_BIT] = level[0];
        end else if (ar_idx == IDX_CFG) begin
            rd_word[7:0] = cfg;
        end else if (ar_idx == IDX_STATUS) begin
            rd_word[1:0] = irq_status;
        end else if (ar_idx == IDX_CLEAR) begin
            rd_word = '0;
        end else if (ar_idx == IDX_ENABLE) begin
            rd_word[1:0] = irq_enable;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= !next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ************************************************************
    // sample tick from the low-speed oscillator
    // ************************************************************
    // the oscillator is far slower than aclk, so its edges are found
    // by sampling; a divider counts them up to 2*n per sample
    logic osc_s1, osc_s2, osc_prev, osc_rise;
    logic [3:0] osc_cnt, osc_limit;
    assign osc_rise = osc_s2 && !osc_prev;
    assign osc_limit = 4'((SAMPLE_BASE << cfg.div_sel) - 4'h1);
    assign tick = osc_rise && (osc_cnt >= osc_limit);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_prev <= 1'b0;
            osc_cnt <= 4'h0;
        end else begin
            osc_s1 <= low_speed_osc_clock;
            osc_s2 <= osc_s1;
            osc_prev <= osc_s2;
            if (tick) begin
                osc_cnt <= 4'h0;
            end else if (osc_rise) begin
                osc_cnt <= osc_cnt + 4'h1;
            end
        end
    end

    // ************************************************************
    // per-channel synchroniser, filter and edge detection
    // ************************************************************
    // a disabled channel, or one whose detector serves the monitors,
    // reads as at-or-above; re-enabling with the input below the reference logs a falling crossing if that edge is selected
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic s1, s2, samp, act_q, level_q;
            assign act[ch] = cfg.chan_enable[ch]
                && !cfg.monitor_mode;
            // edges are judged on the filtered level
            assign evt[ch] = act[ch] && act_q && (level[ch] != level_q)
                && (both_edges[ch]
                || (level[ch] == !cfg.falling_only[ch]));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                end else begin
                    s1 <= raw[ch];
                    s2 <= s1;
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    samp <= 1'b1;
                    level[ch] <= LEVEL_RST[ch];
                    level_q <= LEVEL_RST[ch];
                    act_q <= 1'b0;
                end else begin
                    act_q <= act[ch];
                    level_q <= level[ch];
                    if (!act[ch]) begin
                        level[ch] <= 1'b1;
                    end else if (!cfg.filter_en) begin
                        level[ch] <= s2;
                    end else if (tick) begin
                        samp <= s2;
                        if (s2 == samp) begin
                            level[ch] <= s2;
                        end
                    end
                end
            end
            // sticky event bit, the new event beats a same-cycle clear
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    irq_status[ch] <= 1'b0;
                end else if (evt[ch]) begin
                    irq_status[ch] <= 1'b1;
                end else if (clr_mask[ch]) begin
                    irq_status[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    assign clr_mask = (wr_fire && w_strb[0] && aw_idx == IDX_CLEAR)
        ? w_data[1:0] : 2'h0;

    // ************************************************************
    // pins and interrupt outputs
    // ************************************************************
    logic [1:0] pending, maskable;
    assign pending = irq_status & irq_enable;
    // the per-channel type bits only count under the global enable
    assign maskable = ctrl.type_sel_en
        ? ctrl.irq_maskable : 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp1_result_out <= 1'b0;
            cmp2_result_out <= 1'b0;
            detect_use_monitor <= 1'b0;
            irq <= 1'b0;
            nmi <= 1'b0;
        end else begin
            cmp1_result_out <= ctrl.out_enable[0] && act[0]
                && (level[0] ^ ctrl.out_invert[0]);
            cmp2_result_out <= ctrl.out_enable[1] && act[1]
                && (level[1] ^ ctrl.out_invert[1]);
            detect_use_monitor <= cfg.monitor_mode;
            irq <= |(pending & maskable);
            nmi <= |(pending & ~maskable);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_type_default;
        (|pending) && !ctrl.type_sel_en |=> nmi && !irq;
    endproperty
    a_type_default: assert property (p_type_default)
        else $error("type bits acted without global enable");
    property p_irq_quiet;
        !(|pending) |=> !irq && !nmi;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt raised with nothing pending");
    property p_pin_gate;
        !ctrl.out_enable[0] |=> !cmp1_result_out;
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("output pin driven while disabled");
    property p_pin_invert;
        (ctrl.out_enable[1] && act[1] && ctrl.out_invert[1])
            |=> cmp2_result_out == !$past(level[1]);
    endproperty
    a_pin_invert: assert property (p_pin_invert)
        else $error("inverted pin does not match level");
    property p_monitor_owns;
        cfg.monitor_mode [*2] |-> level == 2'h3 && evt == 2'h0;
    endproperty
    a_monitor_owns: assert property (p_monitor_owns)
        else $error("comparator active in monitor mode");
    // only a software clear may drop the bit once it is set
    property p_event_sticks;
        evt[1] |=> irq_status[1] ##1 (irq_status[1] || $past(clr_mask[1]));
    endproperty
    a_event_sticks: assert property (p_event_sticks)
        else $error("event did not set its status bit");
    property p_one_edge;
        evt[0] && !both_edges[0] |-> level[0] == !cfg.falling_only[0];
    endproperty
    a_one_edge: assert property (p_one_edge)
        else $error("wrong edge accepted in one-edge mode");
    property p_filter_hold;
        cfg.filter_en && act[0] && !tick |=> $stable(level[0]);
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("filtered level moved between samples");
    property p_sync_path;
        (!cfg.filter_en && act[0] && cmp1_analog_in) [*3] |=> level[0];
    endproperty
    a_sync_path: assert property (p_sync_path)
        else $error("unfiltered level did not follow input");
    property p_flag_read;
        s_axi_arvalid && s_axi_arready && ar_idx == IDX_DETECT
            |=> s_axi_rdata[FLAG_BIT] == $past(level[1]);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("detect register flag mismatch");

endmodule : cmp_ctrl

// *** inc/cmp_ctrl_pkg.sv ***
package cmp_ctrl_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IDX_W = 8;
    localparam int NUM_CH = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL = 8'h30;
    localparam logic [IDX_W-1:0] IDX_EDGE = 8'h31;
    localparam logic [IDX_W-1:0] IDX_DETECT = 8'h33;
    localparam logic [IDX_W-1:0] IDX_MON1 = 8'h38;
    localparam logic [IDX_W-1:0] IDX_CFG = 8'h3A;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h3B;
    localparam logic [IDX_W-1:0] IDX_CLEAR = 8'h3C;
    localparam logic [IDX_W-1:0] IDX_ENABLE = 8'h3D;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int FLAG_BIT = 3;
    localparam int EDGE1_BIT = 1;
    localparam int EDGE2_BIT = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] EDGE_RST = 2'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [1:0] LEVEL_RST = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sample period is 2*n low-speed clock edges, n = 1 << div_sel
    localparam logic [3:0] SAMPLE_BASE = 4'h2;

    typedef struct packed {
        logic type_sel_en;
        logic rsvd;
        logic [1:0] irq_maskable;
        logic [1:0] out_enable;
        logic [1:0] out_invert;
    } cmp_ctrl_t;

    typedef struct packed {
        logic [1:0] falling_only;
        logic [1:0] chan_enable;
        logic monitor_mode;
        logic [1:0] div_sel;
        logic filter_en;
    } cmp_cfg_t;

endpackage : cmp_ctrl_pkg

// *** test/cmp_src_model.sv ***
`timescale 1ns/1ps
// ****
// analog sources and low-speed oscillator
// ****
module cmp_src_model #(
    parameter int REF_MV = 500,
    parameter int FAST_NS = 2,
    parameter int SLOW_NS = 7
) (
    input int vin1_mv,
    input int vin2_mv,
    output logic cmp1_analog_in,
    output logic cmp2_analog_in,
    output logic low_speed_osc_clock
);
    // one reference feeds both comparators; ch2 settles slower
    initial begin
        cmp1_analog_in = 1'b1;
        cmp2_analog_in = 1'b1;
        low_speed_osc_clock = 1'b0;
    end
    always @(vin1_mv) begin
        cmp1_analog_in <= #FAST_NS (vin1_mv >= REF_MV);
    end
    always @(vin2_mv) begin
        cmp2_analog_in <= #SLOW_NS (vin2_mv >= REF_MV);
    end
    // oscillator runs free, eight system clocks a period
    always #20 low_speed_osc_clock = ~low_speed_osc_clock;
endmodule : cmp_src_model

// *** test/dual_comparator_control_tb_top.sv ***
`timescale 1ns/1ps
module dual_comparator_control_tb_top;
    import cmp_ctrl_pkg::*;
    typedef struct packed {
        logic cd;
        logic [31:0] d;
        logic [1:0] r;
    } rexp_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cmp1_analog_in, cmp2_analog_in, low_speed_osc_clock;
    logic cmp1_result_out, cmp2_result_out, detect_use_monitor, irq, nmi;
    int vin1 = 900, vin2 = 900;
    int num_errors = 0, checks = 0;
    rexp_t rq[$];
    logic [1:0] bq[$];
    rexp_t re;

    always #2.5 aclk = ~aclk;

    cmp_src_model src (.vin1_mv(vin1), .vin2_mv(vin2),
        .cmp1_analog_in(cmp1_analog_in), .cmp2_analog_in(cmp2_analog_in),
        .low_speed_osc_clock(low_speed_osc_clock));

    cmp_ctrl dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cmp1_analog_in(cmp1_analog_in),
        .cmp2_analog_in(cmp2_analog_in),
        .low_speed_osc_clock(low_speed_osc_clock),
        .cmp1_result_out(cmp1_result_out), .cmp2_result_out(cmp2_result_out),
        .detect_use_monitor(detect_use_monitor), .irq(irq), .nmi(nmi));

    // ****
    // checking
    // ****
    task automatic check_word(input string nm, input logic [31:0] e,
                              input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check_word

    task automatic check_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : check_bit

    task automatic wrap_up();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic give_up(input string nm);
        num_errors++;
        $display("[ERR] %s expected handshake seen timeout", nm);
        wrap_up();
    endtask : give_up

    // responses arrive in issue order, so the oldest note matches
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready && rq.size() > 0) begin
            re = rq.pop_front();
            check_word("rresp", {30'h0, re.r}, {30'h0, s_axi_rresp});
            if (re.cd) check_word("rdata", re.d, s_axi_rdata);
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready && bq.size() > 0) begin
            check_word("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
        end
    end

    // ****
    // bus master
    // ****
    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (++n > 50) give_up("write");
        end
        n = 0;
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            if (++n > 50) give_up("bresp");
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] d,
                      input logic cd = 1'b1, input logic [1:0] r = RESP_OKAY);
        int n;
        n = 0;
        rq.push_back('{cd, d, r});
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (++n > 50) give_up("arready");
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        n = 0;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            if (++n > 50) give_up("rvalid");
        end
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask : tick

    // ****
    // scenarios
    // ****
    initial begin
        logic [31:0] r;
        logic [1:0] inv;
        int n, cnt;
        r = $urandom(32'h6E7F);
        tick(6);
        aresetn <= 1'b1;
        rd(IDX_CTRL, 32'h0);
        rd(IDX_MON1, 32'h8);
        rd(IDX_DETECT, 32'h8);
        rd(8'h00, 32'h0, 1'b0, RESP_SLVERR);
        wr(8'h00, 32'hFF, RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(IDX_ENABLE, 32'h3);
        s_axi_wstrb <= 4'hF;
        rd(IDX_ENABLE, 32'h0);
        wr(IDX_STATUS, 32'h3);
        rd(IDX_STATUS, 32'h0);
        r = $urandom();
        wr(IDX_CTRL, {24'h0, r[7:0]});
        rd(IDX_CTRL, {24'h0, r[7:0] & 8'hBF});
        inv = r[1:0];
        wr(IDX_CFG, 32'h30);
        wr(IDX_EDGE, 32'h0);
        wr(IDX_ENABLE, 32'h3);
        wr(IDX_CTRL, {24'h0, 8'h9C | {6'h0, inv}});
        // falling crossing is ignored in one-edge rising mode
        vin1 <= 100;
        tick(8);
        rd(IDX_STATUS, 32'h0);
        rd(IDX_MON1, 32'h0);
        check_bit("pin1", inv[0], cmp1_result_out);
        check_bit("irq", 1'b0, irq);
        vin1 <= 900;
        tick(8);
        check_bit("irq", 1'b1, irq);
        check_bit("nmi", 1'b0, nmi);
        check_bit("pin1", ~inv[0], cmp1_result_out);
        rd(IDX_STATUS, 32'h1);
        wr(IDX_CLEAR, 32'h1);
        tick(2);
        check_bit("irq", 1'b0, irq);
        wr(IDX_CFG, 32'hB0);
        rd(IDX_CFG, 32'hB0);
        vin2 <= 100;
        tick(8);
        check_bit("nmi", 1'b1, nmi);
        check_bit("irq", 1'b0, irq);
        check_bit("pin2", inv[1], cmp2_result_out);
        rd(IDX_STATUS, 32'h2);
        rd(IDX_DETECT, 32'h0);
        wr(IDX_CLEAR, 32'h2);
        wr(IDX_EDGE, 32'h4);
        rd(IDX_EDGE, 32'h4);
        vin2 <= 900;
        tick(8);
        rd(IDX_STATUS, 32'h2);
        wr(IDX_ENABLE, 32'h1);
        tick(2);
        check_bit("nmi", 1'b0, nmi);
        wr(IDX_CLEAR, 32'h3);
        wr(IDX_ENABLE, 32'h3);
        wr(IDX_CTRL, 32'h1C);
        vin1 <= 100;
        tick(8);
        vin1 <= 900;
        tick(8);
        check_bit("nmi", 1'b1, nmi);
        check_bit("irq", 1'b0, irq);
        wr(IDX_CLEAR, 32'h3);
        wr(IDX_CFG, 32'h38);
        vin1 <= 100;
        tick(8);
        check_bit("monitor", 1'b1, detect_use_monitor);
        rd(IDX_MON1, 32'h8);
        // filtered path: latency lies between one and two sample periods
        n = 1 << $urandom_range(3, 0);
        vin1 <= 900;
        wr(IDX_CFG, 32'h11 | ($clog2(n) << 1));
        wr(IDX_CTRL, 32'h04);
        tick(300);
        check_bit("pin1", 1'b1, cmp1_result_out);
        vin1 <= 100;
        cnt = 0;
        while (cmp1_result_out !== 1'b0 && cnt < 400) begin
            @(posedge aclk);
            cnt++;
        end
        check_bit("filter", 1'b1, cnt >= 16 * n && cnt <= 32 * n + 12);
        wrap_up();
    end
endmodule : dual_comparator_control_tb_top
